// ### verilog/ewa_defs.svh
`ifndef EWA_DEFS_SVH
`define EWA_DEFS_SVH
// direct byte addresses
`define EWA_ADDR_HI 8'h02
`define EWA_ADDR_LO 8'h03
`define EWA_DATA_B0 8'h04
`define EWA_DATA_B3 8'h07
`define EWA_CTRL_HI 8'h08
`define EWA_CTRL_LO 8'h09
`define EWA_KEY_HI 8'h3c
`define EWA_SPEC_HI 8'h1e
// field positions
`define EWA_EXEC_BIT 7
`define EWA_SPEC_MSB 3
// extended map
`define EWA_CUSTOMER_FIELD_ONE_TWO 6'h17
`define EWA_CUSTOMER_FIELD_ONE_ONE 6'h1f
`define EWA_SHADOW_OFS 8'h40
`define EWA_LOCK_OPEN 4'h0
`define EWA_LOCK_NV 4'hc
`define EWA_LOCK_ALL 4'h3
`define EWA_SPEC_LOW 4'h1
`define EWA_SPEC_HIGH 4'h2
`define EWA_SPEC_NORMAL 4'h0
// keycode sequence
`define EWA_KEY_0 8'h00
`define EWA_KEY_1 8'h27
`define EWA_KEY_2 8'h81
`define EWA_KEY_3 8'h1f
`define EWA_KEY_4 8'h77
`define EWA_KEY_LAST 3'h4
// timing
`define EWA_NV_WRITE_MS 24
`define EWA_CLK_KHZ 20000
`endif

// ### verilog/ewa_pkg.sv
package ewa_pkg;
   // protection fields read from the nonvolatile store
   typedef struct packed {
      logic [3:0] lock;
      logic customerUseDisable;
      logic lockBypass;
      logic unlockBypass;
   } ewa_cfg_type;
   // staged write for the memory side
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] data;
   } ewa_req_type;
   typedef enum logic [1:0] {
      EWA_IDLE,
      EWA_CHECK,
      EWA_NVWAIT
   } ewa_state_type;
endpackage

// ### verilog/ewa_ext_write.sv
`timescale 1ns/1ns
`default_nettype none
`include "ewa_defs.svh"
module ewa_ext_write #(
   parameter int NV_TIMEOUT_CYC = `EWA_NV_WRITE_MS * `EWA_CLK_KHZ
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic regWrStrobe,
   input wire logic [7:0] regWrAddr,
   input wire logic [7:0] regWrData,
   input wire logic regRdStrobe,
   input wire logic [7:0] regRdAddr,
   output logic [15:0] regRdData,
   output logic regRdValid,
   input wire ewa_pkg::ewa_cfg_type cfgFields,
   output ewa_pkg::ewa_req_type writeReq,
   output logic nvWriteStart,
   input wire logic nvWriteDone,
   input wire logic nvWriteAbort,
   output logic shadowWriteEn,
   output logic [3:0] senseMode,
   output logic writeBusy,
   output logic writeDone,
   output logic extAccessWarn,
   output logic extAccessError,
   input wire logic clearWarn,
   input wire logic clearError
);
   // ****************************************************
   // staged registers
   // ****************************************************
   logic [7:0] addrQ;
   logic [31:0] dataQ;
   logic [3:0] specialQ;
   logic trigQ;
   logic doneQ;
   logic warnQ;
   logic errQ;
   logic unlockedQ;
   logic [2:0] keyStepQ;
   logic [18:0] nvCountQ;
   logic nvStartQ;
   logic shadowWeQ;
   logic [15:0] rdDataQ;
   logic rdValidQ;
   ewa_pkg::ewa_state_type stateQ;
   logic permitted;
   logic isShadow;
   logic execWrite;
   logic timeout;

   // expected keycode byte at each step
   function automatic logic [7:0] keyByte(input logic [2:0] step);
      case (step)
         3'h0: keyByte = `EWA_KEY_0;
         3'h1: keyByte = `EWA_KEY_1;
         3'h2: keyByte = `EWA_KEY_2;
         3'h3: keyByte = `EWA_KEY_3;
         default: keyByte = `EWA_KEY_4;
      endcase
   endfunction

   // write permission for one extended address
   function automatic logic allowWrite(input logic [7:0] xa, input ewa_pkg::ewa_cfg_type c,
                                       input logic unl);
      logic locked;
      logic custField;
      logic [5:0] base;
      base = xa[5:0]; // shadow shares its cell's customer-field rule
      locked = (c.lock == `EWA_LOCK_ALL) ||
               ((c.lock == `EWA_LOCK_NV) && (xa < `EWA_SHADOW_OFS));
      custField = (base == `EWA_CUSTOMER_FIELD_ONE_TWO) || ((base == `EWA_CUSTOMER_FIELD_ONE_ONE) && c.customerUseDisable);
      if (custField) begin
         allowWrite = (!locked || c.lockBypass) && (c.unlockBypass || unl);
      end else begin
         allowWrite = !locked && unl;
      end
   endfunction

   assign execWrite = regWrStrobe && (regWrAddr == `EWA_CTRL_HI) && regWrData[`EWA_EXEC_BIT];
   assign isShadow = addrQ >= `EWA_SHADOW_OFS;
   assign permitted = allowWrite(addrQ, cfgFields, unlockedQ);
   assign timeout = nvCountQ == 19'(NV_TIMEOUT_CYC - 1);

   // ****************************************************
   // staged address and data
   // ****************************************************
   // address low byte and data bytes, most significant first
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         addrQ <= 8'h00;
         dataQ <= 32'h0000_0000;
      end else if (regWrStrobe) begin
         if (regWrAddr == `EWA_ADDR_LO) begin
            addrQ <= regWrData;
         end
         if (regWrAddr >= `EWA_DATA_B0 && regWrAddr <= `EWA_DATA_B3) begin
            case (regWrAddr[1:0])
               2'h0: dataQ[31:24] <= regWrData;
               2'h1: dataQ[23:16] <= regWrData;
               2'h2: dataQ[15:8] <= regWrData;
               default: dataQ[7:0] <= regWrData;
            endcase
         end
      end
   end

   // ****************************************************
   // keycode and margin mode
   // ****************************************************
   // five writes in order unlock until power cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         keyStepQ <= 3'h0;
         unlockedQ <= 1'b0;
      end else if (regWrStrobe && regWrAddr == `EWA_KEY_HI && !unlockedQ) begin
         if (regWrData == keyByte(keyStepQ)) begin
            if (keyStepQ == `EWA_KEY_LAST) begin
               unlockedQ <= 1'b1;
            end else begin
               keyStepQ <= keyStepQ + 3'h1;
            end
         end else if (regWrData == `EWA_KEY_0) begin
            keyStepQ <= 3'h1;
         end else begin
            keyStepQ <= 3'h0;
         end
      end
   end

   // only the two margin values are kept
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         specialQ <= `EWA_SPEC_NORMAL;
      end else if (regWrStrobe && regWrAddr == `EWA_SPEC_HI) begin
         if (regWrData[`EWA_SPEC_MSB:0] == `EWA_SPEC_LOW ||
             regWrData[`EWA_SPEC_MSB:0] == `EWA_SPEC_HIGH) begin
            specialQ <= regWrData[`EWA_SPEC_MSB:0];
         end else begin
            specialQ <= `EWA_SPEC_NORMAL;
         end
      end
   end

   // ****************************************************
   // write sequencer
   // ****************************************************
   // trigger is synchronised one cycle, then checked
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stateQ <= ewa_pkg::EWA_IDLE;
         trigQ <= 1'b0;
         nvStartQ <= 1'b0;
         shadowWeQ <= 1'b0;
         nvCountQ <= 19'h0_0000;
      end else begin
         trigQ <= execWrite && stateQ == ewa_pkg::EWA_IDLE && !trigQ;
         nvStartQ <= 1'b0;
         shadowWeQ <= 1'b0;
         case (stateQ)
            ewa_pkg::EWA_IDLE: begin
               if (trigQ) begin
                  stateQ <= ewa_pkg::EWA_CHECK;
               end
            end
            ewa_pkg::EWA_CHECK: begin
               if (!permitted) begin
                  stateQ <= ewa_pkg::EWA_IDLE;
               end else if (isShadow) begin
                  shadowWeQ <= 1'b1;
                  stateQ <= ewa_pkg::EWA_IDLE;
               end else begin
                  nvStartQ <= 1'b1;
                  nvCountQ <= 19'h0_0000;
                  stateQ <= ewa_pkg::EWA_NVWAIT;
               end
            end
            ewa_pkg::EWA_NVWAIT: begin
               nvCountQ <= nvCountQ + 19'h0_0001;
               if (nvWriteDone || nvWriteAbort || timeout) begin
                  stateQ <= ewa_pkg::EWA_IDLE;
               end
            end
            default: stateQ <= ewa_pkg::EWA_IDLE;
         endcase
      end
   end

   // done clears on a new execute, sets at every finish
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         doneQ <= 1'b0;
      end else if (stateQ == ewa_pkg::EWA_CHECK && (!permitted || isShadow)) begin
         doneQ <= 1'b1;
      end else if (stateQ == ewa_pkg::EWA_NVWAIT && (nvWriteDone || nvWriteAbort || timeout)) begin
         doneQ <= 1'b1;
      end else if (trigQ) begin
         doneQ <= 1'b0;
      end
   end

   // sticky warning and error, set wins over clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         warnQ <= 1'b0;
         errQ <= 1'b0;
      end else begin
         if (stateQ == ewa_pkg::EWA_CHECK && !permitted) begin
            warnQ <= 1'b1;
         end else if (clearWarn) begin
            warnQ <= 1'b0;
         end
         if (stateQ == ewa_pkg::EWA_NVWAIT && (nvWriteAbort || timeout) && !nvWriteDone) begin
            errQ <= 1'b1;
         end else if (clearError) begin
            errQ <= 1'b0;
         end
      end
   end

   // ****************************************************
   // read port
   // ****************************************************
   // word reads; odd address gives low byte only
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdDataQ <= 16'h0000;
         rdValidQ <= 1'b0;
      end else begin
         rdValidQ <= regRdStrobe;
         if (regRdStrobe) begin
            case ({regRdAddr[7:1], 1'b0})
               `EWA_ADDR_HI: rdDataQ <= {8'h00, addrQ};
               `EWA_DATA_B0: rdDataQ <= dataQ[31:16];
               `EWA_DATA_B0 + 8'h02: rdDataQ <= dataQ[15:0];
               `EWA_CTRL_HI: rdDataQ <= {7'h00, stateQ != ewa_pkg::EWA_IDLE || trigQ, 7'h00, doneQ};
               `EWA_SPEC_HI: rdDataQ <= {4'h0, specialQ, 8'h00};
               default: rdDataQ <= 16'h0000;
            endcase
            if (regRdAddr[0]) begin
               rdDataQ[15:8] <= 8'h00;
            end
         end
      end
   end

   assign regRdData = rdDataQ;
   assign regRdValid = rdValidQ;
   assign writeReq = {addrQ, dataQ};
   assign nvWriteStart = nvStartQ;
   assign shadowWriteEn = shadowWeQ;
   assign senseMode = specialQ;
   assign writeBusy = stateQ != ewa_pkg::EWA_IDLE || trigQ;
   assign writeDone = doneQ;
   assign extAccessWarn = warnQ;
   assign extAccessError = errQ;

   // ****************************************************
   // checks
   // ****************************************************
   a_exec_starts: assert property (@(posedge clk) disable iff (reset)
      execWrite && !writeBusy |=> trigQ ##1 stateQ == ewa_pkg::EWA_CHECK)
      else $error("execute did not start a write");
   a_exec_zero_idle: assert property (@(posedge clk) disable iff (reset)
      regWrStrobe && regWrAddr == `EWA_CTRL_HI && !execWrite && !writeBusy |=> !trigQ)
      else $error("execute clear started a write");
   a_shadow_fast: assert property (@(posedge clk) disable iff (reset)
      stateQ == ewa_pkg::EWA_CHECK && isShadow && permitted |=> shadowWriteEn && writeDone && !writeBusy)
      else $error("shadow write not one cycle");
   a_violation_flags: assert property (@(posedge clk) disable iff (reset)
      stateQ == ewa_pkg::EWA_CHECK && !permitted |=> writeDone && extAccessWarn && !nvWriteStart && !shadowWriteEn)
      else $error("violation not reported");
   a_abort_error: assert property (@(posedge clk) disable iff (reset)
      stateQ == ewa_pkg::EWA_NVWAIT && nvWriteAbort && !nvWriteDone |=> extAccessError && writeDone)
      else $error("abort did not set error");
   a_locked_other: assert property (@(posedge clk) disable iff (reset)
      nvWriteStart && writeReq.addr[5:0] != `EWA_CUSTOMER_FIELD_ONE_TWO && writeReq.addr[5:0] != `EWA_CUSTOMER_FIELD_ONE_ONE
      |-> cfgFields.lock != `EWA_LOCK_NV && cfgFields.lock != `EWA_LOCK_ALL && unlockedQ)
      else $error("locked location written");
   a_key_unlock: assert property (@(posedge clk) disable iff (reset)
      regWrStrobe && regWrAddr == `EWA_KEY_HI && keyStepQ == `EWA_KEY_LAST && regWrData == `EWA_KEY_4
      |=> unlockedQ)
      else $error("keycode did not unlock");
   a_margin_hold: assert property (@(posedge clk) disable iff (reset)
      senseMode == `EWA_SPEC_LOW && !(regWrStrobe && regWrAddr == `EWA_SPEC_HI) |=> $stable(senseMode))
      else $error("margin mode lost");
   a_done_readback: assert property (@(posedge clk) disable iff (reset)
      regRdStrobe && regRdAddr == `EWA_CTRL_HI |=> regRdValid && regRdData[0] == $past(doneQ))
      else $error("done flag not at bit 0");
endmodule
`default_nettype wire

// ### tb/ewa_store_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// nonvolatile store stand-in
// ****
module ewa_store_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic nvWriteStart,
   input wire logic [1:0] mode,
   input wire logic [3:0] lat,
   output logic nvWriteDone,
   output logic nvWriteAbort
);
   logic [3:0] wait_q;
   // answers lat cycles after start: mode 0 done, 1 abort, 2 silent
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wait_q <= 4'h0;
         nvWriteDone <= 1'b0;
         nvWriteAbort <= 1'b0;
      end else begin
         nvWriteDone <= 1'b0;
         nvWriteAbort <= 1'b0;
         if (nvWriteStart) begin
            wait_q <= lat;
         end else if (wait_q == 4'h1) begin
            wait_q <= 4'h0;
            nvWriteDone <= (mode == 2'h0);
            nvWriteAbort <= (mode == 2'h1);
         end else if (wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ewa_defs.svh"
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin failures++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb;
   logic clk, reset, regWrStrobe, regRdStrobe, regRdValid, clearWarn, clearError;
   logic [7:0] regWrAddr, regWrData, regRdAddr;
   logic [15:0] regRdData, expRd;
   ewa_pkg::ewa_cfg_type cfgFields;
   ewa_pkg::ewa_req_type writeReq;
   logic nvWriteStart, nvWriteDone, nvWriteAbort, shadowWriteEn, writeBusy, writeDone;
   logic extAccessWarn, extAccessError;
   logic [3:0] senseMode, storeLat, specVal;
   logic [1:0] storeMode;
   logic [15:0] expQ[$];
   logic [31:0] stagedData;
   int failures, testsRun, shCnt, nvCnt, sh0;
   integer seed = 32'hf70b;
   ewa_ext_write #(.NV_TIMEOUT_CYC(20)) dut_u (.clk(clk), .reset(reset), .regWrStrobe(regWrStrobe),
      .regWrAddr(regWrAddr), .regWrData(regWrData), .regRdStrobe(regRdStrobe), .regRdAddr(regRdAddr),
      .regRdData(regRdData), .regRdValid(regRdValid), .cfgFields(cfgFields), .writeReq(writeReq),
      .nvWriteStart(nvWriteStart), .nvWriteDone(nvWriteDone), .nvWriteAbort(nvWriteAbort),
      .shadowWriteEn(shadowWriteEn), .senseMode(senseMode), .writeBusy(writeBusy), .writeDone(writeDone),
      .extAccessWarn(extAccessWarn), .extAccessError(extAccessError), .clearWarn(clearWarn),
      .clearError(clearError));
   ewa_store_model store_u (.clk(clk), .reset(reset), .nvWriteStart(nvWriteStart), .mode(storeMode),
      .lat(storeLat), .nvWriteDone(nvWriteDone), .nvWriteAbort(nvWriteAbort));
   // ****
   // clock, monitors, tasks
   // ****
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // pulse counters and read scoreboard
   always @(negedge clk) begin
      if (shadowWriteEn === 1'b1) shCnt++;
      if (nvWriteStart === 1'b1) nvCnt++;
      if (regRdValid === 1'b1) begin
         expRd = (expQ.size() != 0) ? expQ.pop_front() : 16'hxxxx;
         `CHK(regRdData, expRd)
      end
   end
   task automatic tick();
      @(posedge clk);
      #2;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      tick();
      regWrAddr = a;
      regWrData = d;
      regWrStrobe = 1'b1;
      tick();
      regWrStrobe = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      tick();
      regRdAddr = a;
      regRdStrobe = 1'b1;
      expQ.push_back(e);
      tick();
      regRdStrobe = 1'b0;
   endtask
   task automatic resetDut();
      tick();
      tick();
      reset = 1'b1;
      repeat (16) @(posedge clk);
      #2;
      reset = 1'b0;
   endtask
   function automatic logic allowed(input ewa_pkg::ewa_cfg_type c, input logic [7:0] a, input logic unl);
      logic lk;
      logic two;
      lk = (c.lock == `EWA_LOCK_ALL) || (a < `EWA_SHADOW_OFS && c.lock == `EWA_LOCK_NV);
      two = (a[5:0] == `EWA_CUSTOMER_FIELD_ONE_TWO) || (a[5:0] == `EWA_CUSTOMER_FIELD_ONE_ONE && c.customerUseDisable);
      if (two) return (!lk || c.lockBypass) && (c.unlockBypass || unl);
      return !lk && unl;
   endfunction
   // one extended write with bounded waits, then outcome checks
   task automatic xw(input logic [7:0] a, input logic unl);
      logic ok;
      int n;
      int nv0;
      ok = allowed(cfgFields, a, unl);
      storeMode = 2'($unsigned($random(seed)) % 3);
      storeLat = 4'(1 + $unsigned($random(seed)) % 15);
      tick();
      clearWarn = 1'b1;
      clearError = 1'b1;
      tick();
      clearWarn = 1'b0;
      clearError = 1'b0;
      wr(`EWA_ADDR_LO, a);
      sh0 = shCnt;
      nv0 = nvCnt;
      wr(`EWA_CTRL_HI, 8'h80);
      n = 0;
      while (writeBusy !== 1'b1 && n < 5) begin
         tick();
         n++;
      end
      n = 0;
      while (!(writeDone === 1'b1 && writeBusy === 1'b0) && n < 60) begin
         tick();
         n++;
      end
      tick();
      `CHK(n < 60, 1'b1)
      `CHK(extAccessWarn, !ok)
      `CHK(shCnt - sh0, int'(ok && a >= 8'h40))
      `CHK(nvCnt - nv0, int'(ok && a < 8'h40))
      `CHK(extAccessError, ok && a < 8'h40 && storeMode != 2'h0)
      if (ok && a >= 8'h40) `CHK(n <= 4, 1'b1)
      `CHK(writeReq.addr, a)
      rd(`EWA_CTRL_HI, 16'h0001);
   endtask
   task automatic permLoop(input logic unl);
      logic [3:0] locks [4] = '{`EWA_LOCK_OPEN, `EWA_LOCK_NV, `EWA_LOCK_ALL, 4'h6};
      logic [7:0] addrs [6] = '{8'h17, 8'h1f, 8'h05, 8'h57, 8'h5f, 8'h45};
      logic [31:0] r;
      repeat (24) begin
         r = $random(seed);
         cfgFields = {locks[r[1:0]], r[4:2]};
         xw(addrs[r[7:5] % 6], unl);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // watchdog: over twenty times the expected run
   initial begin
      #1000000;
      failures++;
      wrap_up();
   end
   // ****
   // main sequence
   // ****
   initial begin
      {reset, regWrStrobe, regRdStrobe, clearWarn, clearError} = 5'h10;
      {regWrAddr, regWrData, regRdAddr} = 24'h0;
      cfgFields = '0;
      {storeMode, storeLat} = 6'h1;
      resetDut();
      rd(`EWA_CTRL_HI, 16'h0000);
      rd(`EWA_SPEC_HI, 16'h0000);
      rd(8'h3e, 16'h0000);
      $display("test reset done");
      stagedData = $random(seed);
      for (int i = 0; i < 4; i++) wr(8'(`EWA_DATA_B0 + i), stagedData[31 - 8 * i -: 8]);
      wr(`EWA_ADDR_LO, 8'h45);
      rd(`EWA_DATA_B0, stagedData[31:16]);
      rd(8'h06, stagedData[15:0]);
      rd(`EWA_ADDR_HI, 16'h0045);
      rd(`EWA_ADDR_LO, 16'h0045);
      sh0 = shCnt + nvCnt;
      wr(`EWA_CTRL_HI, 8'h00);
      repeat (6) tick();
      `CHK(shCnt + nvCnt, sh0)
      `CHK(writeReq, {8'h45, stagedData})
      $display("test staging done");
      permLoop(1'b0);
      wr(`EWA_KEY_HI, `EWA_KEY_0);
      wr(`EWA_KEY_HI, `EWA_KEY_1);
      wr(`EWA_KEY_HI, 8'h55);
      cfgFields = '0;
      xw(8'h45, 1'b0);
      wr(`EWA_KEY_HI, `EWA_KEY_0);
      wr(`EWA_KEY_HI, `EWA_KEY_1);
      wr(`EWA_KEY_HI, `EWA_KEY_2);
      wr(`EWA_KEY_HI, `EWA_KEY_3);
      wr(`EWA_KEY_HI, `EWA_KEY_4);
      permLoop(1'b1);
      $display("test permissions done");
      // margin read-back after the writes above
      for (int i = 0; i < 5; i++) begin
         specVal = 4'(i == 4 ? 0 : (i == 3 ? 5 : i + 1));
         wr(`EWA_SPEC_HI, {4'h0, specVal});
         if (specVal > `EWA_SPEC_HIGH) specVal = `EWA_SPEC_NORMAL;
         rd(`EWA_SPEC_HI, {4'h0, specVal, 8'h00});
         `CHK(senseMode, specVal)
      end
      $display("test margin done");
      resetDut();
      `CHK(senseMode, `EWA_SPEC_NORMAL)
      cfgFields = '0;
      xw(8'h45, 1'b0);
      repeat (4) tick();
      `CHK(expQ.size(), 0)
      $display("test second reset done");
      wrap_up();
   end
endmodule
`default_nettype wire
